// ---- rtl/vsr_pkg.sv ----
package vsr_pkg;
   // Parameter block layout, word indices
   localparam logic [3:0]  PB_CODE      = 4'h0;
   localparam logic [3:0]  PB_OPTS      = 4'h1;
   localparam logic [3:0]  PB_RETSTAT   = 4'h2;
   localparam logic [3:0]  PB_VECTORS   = 4'h4;
   localparam logic [3:0]  PB_LEVEL     = 4'h5;
   localparam logic [3:0]  PB_BUSID     = 4'hE;
   localparam logic [3:0]  PB_LAST      = 4'hE;
   localparam int          PB_WORDS     = 16;
   // Command codes and field positions
   localparam logic [15:0] CMD_BUS_RST  = 16'h0022;
   localparam int          OPT_IE_BIT   = 0;
   localparam int          BUSID_BIT    = 15;
   localparam int          LVL_MSB      = 2;
   localparam logic [15:0] LVL_MASK     = 16'h0007;
   localparam logic [15:0] OPT_MASK     = 16'h0001;
   localparam logic [15:0] BUSID_MASK   = 16'h8000;
   // Status codes; values are arbitrary
   localparam logic [7:0]  ST_OK        = 8'h00;
   localparam logic [7:0]  ST_BAD_CMD   = 8'h01;
   localparam logic [7:0]  ST_SCSI_RST  = 8'h02;
   // Timing: SCSI bus reset hold time
   localparam int          RST_HOLD_NS  = 25000;
   localparam int          CLK_NS       = 25;
   localparam int          RST_CYC      = RST_HOLD_NS / CLK_NS;
   // Host APB register offsets
   localparam logic [7:0]  A_CTRL       = 8'h00;
   localparam logic [7:0]  A_VEC        = 8'h04;
   localparam logic [7:0]  A_LVL        = 8'h08;
   localparam logic [7:0]  A_STAT       = 8'h0C;
   localparam logic [7:0]  A_INT_STAT   = 8'h10;
   localparam logic [7:0]  A_INT_MASK   = 8'h14;
   // Control bits
   localparam int          C_GO         = 0;
   localparam int          C_IE         = 1;
   localparam int          C_BUS        = 2;
   localparam int          C_FREEZE     = 3;
   localparam int          C_INIT       = 4;
   // Interrupt status bits
   localparam int          I_DONE       = 0;
   localparam int          I_ERR        = 1;
   localparam int          I_REFUSED    = 2;
   localparam int          I_SENSE      = 3;
   localparam int          I_BITS       = 4;
endpackage

// ---- rtl/vsr_if.sv ----
`timescale 1ns/1ps
interface vsr_if;
   logic        pb_we;
   logic [3:0]  pb_addr;
   logic [15:0] pb_wdata;
   logic [15:0] pb_rdata;
   logic        mce_go;
   logic        busy;
   logic        irq_req;
   logic [2:0]  irq_priority_level;
   logic [7:0]  irq_vec;
   logic        irq_ack;
   logic        init_we;
   logic        init_freeze;
   modport dev  (input  pb_we, pb_addr, pb_wdata, mce_go, irq_ack, init_we, init_freeze,
                 output pb_rdata, busy, irq_req, irq_priority_level, irq_vec);
   modport host (output pb_we, pb_addr, pb_wdata, mce_go, irq_ack, init_we, init_freeze,
                 input  pb_rdata, busy, irq_req, irq_priority_level, irq_vec);
endinterface

// ---- rtl/vsr_dev.sv ----
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module vsr_dev #(
   parameter int NQ      = 8,
   parameter int RST_LEN = vsr_pkg::RST_CYC
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   vsr_if.dev                    lnk,
   input  wire logic [NQ-1:0]    q_act_p0,
   input  wire logic [NQ-1:0]    q_act_p1,
   input  wire logic [NQ-1:0]    q_unfreeze,
   output logic [1:0]            scsi_rst_ff,
   output logic                  abort_valid_ff,
   output logic [$clog2(NQ)-1:0] abort_queue_ff,
   output logic [7:0]            abort_stat_ff,
   output logic [NQ-1:0]         frozen_ff
);
   localparam int QW = $clog2(NQ);

   // Refuse sizes the queue index and reset counter cannot hold
   if (NQ < 2 || RST_LEN < 1 || RST_LEN > 65535) begin : g_bad_param
      $error("vsr_dev: unsupported parameter value");
   end

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_CHECK  = 3'b001,
      S_RESET  = 3'b010,
      S_ABORT  = 3'b011,
      S_STATUS = 3'b100,
      S_IRQ    = 3'b101
   } vsr_dstate_t;

   // Lowest set bit of a pending mask
   function automatic logic [QW-1:0] first_one(input logic [NQ-1:0] m);
      logic [QW-1:0] r;
      r = '0;
      for (int i = NQ - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = QW'(i);
         end
      end
      return r;
   endfunction

   logic [15:0]     pb_mem [vsr_pkg::PB_WORDS];
   vsr_dstate_t     state_ff;
   vsr_dstate_t     nxt_state;
   logic            freeze_en_ff;
   logic            port_ff;
   logic [NQ-1:0]   pend_ff;
   logic [15:0]     rst_cnt_ff;
   logic [7:0]      code_ff;
   logic [15:0]     rdata_ff;
   logic            busy_ff;
   logic            irq_req_ff;
   logic [2:0]      lvl_ff;
   logic [7:0]      vec_ff;

   // Decode of the held parameter block
   wire             is_bus_rst = (pb_mem[vsr_pkg::PB_CODE] == vsr_pkg::CMD_BUS_RST);
   wire             sel_port   = pb_mem[vsr_pkg::PB_BUSID][vsr_pkg::BUSID_BIT];
   wire             ie_bit     = pb_mem[vsr_pkg::PB_OPTS][vsr_pkg::OPT_IE_BIT];
   wire [NQ-1:0]    act_sel    = sel_port ? q_act_p1 : q_act_p0;
   wire [QW-1:0]    abt_idx    = first_one(pend_ff);
   wire             rst_done   = (rst_cnt_ff == 16'h0001);
   wire             st_write   = (state_ff == S_STATUS);
   wire [15:0]      vec_word   = pb_mem[vsr_pkg::PB_VECTORS];
   wire [7:0]       sel_vec    = (code_ff != vsr_pkg::ST_OK) ? vec_word[7:0]
                                                              : vec_word[15:8];
   wire [NQ-1:0]    abt_onehot = NQ'(1) << abt_idx;

   // Sequence: decode, reset, abort, write status, interrupt
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE:   if (lnk.mce_go) nxt_state = S_CHECK;
         S_CHECK:  nxt_state = is_bus_rst ? S_RESET : S_STATUS;
         S_RESET:  if (rst_done) nxt_state = S_ABORT;
         S_ABORT:  if (pend_ff == '0) nxt_state = S_STATUS;
         S_STATUS: nxt_state = ie_bit ? S_IRQ : S_IDLE;
         S_IRQ:    if (lnk.irq_ack) nxt_state = S_IDLE;
         default:  nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= S_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Parameter block store; status write-back has the port while busy
   always_ff @(posedge pclk) begin
      if (st_write) begin
         pb_mem[vsr_pkg::PB_RETSTAT] <= {8'h00, code_ff};
      end else if (lnk.pb_we && !busy_ff) begin
         pb_mem[lnk.pb_addr] <= lnk.pb_wdata;
      end
   end

   // Registered read port and freeze option held from initialization
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff     <= 16'h0000;
         freeze_en_ff <= 1'b0;
      end else begin
         rdata_ff <= pb_mem[lnk.pb_addr];
         if (lnk.init_we) begin
            freeze_en_ff <= lnk.init_freeze;
         end
      end
   end

   // Bus reset drive, port capture and hold counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_ff     <= 1'b0;
         rst_cnt_ff  <= 16'h0000;
         scsi_rst_ff <= 2'b00;
      end else if (state_ff == S_CHECK && is_bus_rst) begin
         port_ff     <= sel_port;
         rst_cnt_ff  <= 16'(RST_LEN);
         scsi_rst_ff <= sel_port ? 2'b10 : 2'b01;
      end else if (state_ff == S_RESET) begin
         rst_cnt_ff <= rst_cnt_ff - 16'h0001;
         if (rst_done) begin
            scsi_rst_ff <= 2'b00;
         end
      end
   end

   // Abort each pending queue in turn, one completion per cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff        <= '0;
         abort_valid_ff <= 1'b0;
         abort_queue_ff <= '0;
         abort_stat_ff  <= 8'h00;
      end else begin
         abort_valid_ff <= 1'b0;
         if (state_ff == S_RESET && rst_done) begin
            pend_ff <= port_ff ? q_act_p1 : q_act_p0;
         end else if (state_ff == S_ABORT && pend_ff != '0) begin
            pend_ff        <= pend_ff & ~abt_onehot;
            abort_valid_ff <= 1'b1;
            abort_queue_ff <= abt_idx;
            abort_stat_ff  <= vsr_pkg::ST_SCSI_RST;
         end
      end
   end

   // Queue freeze; a new freeze wins over a release in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frozen_ff <= '0;
      end else if (state_ff == S_ABORT && pend_ff != '0 && freeze_en_ff) begin
         frozen_ff <= (frozen_ff & ~q_unfreeze) | abt_onehot;
      end else begin
         frozen_ff <= frozen_ff & ~q_unfreeze;
      end
   end

   // Result code, busy flag and completion interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_ff    <= 8'h00;
         busy_ff    <= 1'b0;
         irq_req_ff <= 1'b0;
         lvl_ff     <= 3'b000;
         vec_ff     <= 8'h00;
      end else begin
         if (state_ff == S_CHECK) begin
            code_ff <= is_bus_rst ? vsr_pkg::ST_OK : vsr_pkg::ST_BAD_CMD;
         end
         if (state_ff == S_IDLE && lnk.mce_go) begin
            busy_ff <= 1'b1;
         end else if (nxt_state == S_IDLE) begin
            busy_ff <= 1'b0;
         end
         if (st_write && ie_bit) begin
            irq_req_ff <= 1'b1;
            lvl_ff     <= pb_mem[vsr_pkg::PB_LEVEL][vsr_pkg::LVL_MSB:0];
            vec_ff     <= sel_vec;
         end else if (state_ff == S_IRQ && lnk.irq_ack) begin
            irq_req_ff <= 1'b0;
         end
      end
   end

   assign lnk.pb_rdata           = rdata_ff;
   assign lnk.busy               = busy_ff;
   assign lnk.irq_req            = irq_req_ff;
   assign lnk.irq_priority_level = lvl_ff;
   assign lnk.irq_vec            = vec_ff;
endmodule

// ---- rtl/vsr_host.sv ----
`timescale 1ns/1ps
module vsr_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   vsr_if.host              lnk,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata_ff,
   output logic             pready_ff,
   output logic             pslverr_ff,
   output logic             irq_ff
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_FILL = 3'b001,
      H_GO   = 3'b010,
      H_WAIT = 3'b011,
      H_RD1  = 3'b100,
      H_RD2  = 3'b101,
      H_ACK  = 3'b110
   } vsr_hstate_t;

   vsr_hstate_t          st_ff;
   logic [3:0]           idx_ff;
   logic                 ie_ff;
   logic                 bus_ff;
   logic                 frz_ff;
   logic [15:0]          vec_ff;
   logic [2:0]           lvl_ff;
   logic [15:0]          ret_ff;
   logic                 irqseen_ff;
   logic [vsr_pkg::I_BITS-1:0] ist_ff;
   logic [vsr_pkg::I_BITS-1:0] imask_ff;
   logic                 pb_we_ff;
   logic [3:0]           pb_addr_ff;
   logic [15:0]          pb_wdata_ff;
   logic                 go_ff;
   logic                 ack_ff;
   logic                 init_ff;

   // APB decode
   wire        setup   = psel && !penable;
   wire        wr_acc  = psel && penable && pwrite;
   wire        wr_ctrl = wr_acc && paddr == vsr_pkg::A_CTRL;
   wire        mapped  = paddr == vsr_pkg::A_CTRL || paddr == vsr_pkg::A_VEC ||
                         paddr == vsr_pkg::A_LVL  || paddr == vsr_pkg::A_STAT ||
                         paddr == vsr_pkg::A_INT_STAT || paddr == vsr_pkg::A_INT_MASK;
   wire        start   = wr_ctrl && pwdata[vsr_pkg::C_GO] && st_ff == H_IDLE;
   wire        bad_lvl = pwdata[vsr_pkg::C_IE] && lvl_ff == 3'b000;
   wire        cmpl    = st_ff == H_RD2;
   wire [vsr_pkg::I_BITS-1:0] ev = {cmpl, start && bad_lvl,
                                    cmpl && lnk.pb_rdata != 16'h0000, cmpl};
   // Block words with every reserved bit zero
   wire [15:0] fill_w  =
      (idx_ff == vsr_pkg::PB_CODE)    ? vsr_pkg::CMD_BUS_RST :
      (idx_ff == vsr_pkg::PB_OPTS)    ? (16'(ie_ff) & vsr_pkg::OPT_MASK) :
      (idx_ff == vsr_pkg::PB_VECTORS) ? vec_ff :
      (idx_ff == vsr_pkg::PB_LEVEL)   ? (16'(lvl_ff) & vsr_pkg::LVL_MASK) :
      (idx_ff == vsr_pkg::PB_BUSID)   ? ({bus_ff, 15'h0000} & vsr_pkg::BUSID_MASK) :
                                        16'h0000;

   // APB slave: zero wait states, data staged in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h00000000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= 1'b1;
         if (setup) begin
            pslverr_ff <= !mapped;
            case (paddr)
               vsr_pkg::A_CTRL:     prdata_ff <= {27'h0000000, 1'b0, frz_ff, bus_ff, ie_ff, 1'b0};
               vsr_pkg::A_VEC:      prdata_ff <= {16'h0000, vec_ff};
               vsr_pkg::A_LVL:      prdata_ff <= {29'h00000000, lvl_ff};
               vsr_pkg::A_STAT:     prdata_ff <= {ret_ff, 15'h0000, st_ff != H_IDLE};
               vsr_pkg::A_INT_STAT: prdata_ff <= {28'h0000000, ist_ff};
               vsr_pkg::A_INT_MASK: prdata_ff <= {28'h0000000, imask_ff};
               default:             prdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // Software settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_ff    <= 1'b0;
         bus_ff   <= 1'b0;
         frz_ff   <= 1'b0;
         vec_ff   <= 16'h0000;
         lvl_ff   <= 3'b000;
         imask_ff <= '0;
         init_ff  <= 1'b0;
      end else begin
         init_ff <= wr_ctrl && pwdata[vsr_pkg::C_INIT];
         if (wr_ctrl && st_ff == H_IDLE) begin
            ie_ff  <= pwdata[vsr_pkg::C_IE];
            bus_ff <= pwdata[vsr_pkg::C_BUS];
            frz_ff <= pwdata[vsr_pkg::C_FREEZE];
         end
         if (wr_acc && paddr == vsr_pkg::A_VEC) vec_ff <= pwdata[15:0];
         if (wr_acc && paddr == vsr_pkg::A_LVL) lvl_ff <= pwdata[2:0];
         if (wr_acc && paddr == vsr_pkg::A_INT_MASK) imask_ff <= pwdata[vsr_pkg::I_BITS-1:0];
      end
   end

   // Sticky events, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         if (wr_acc && paddr == vsr_pkg::A_INT_STAT) begin
            ist_ff <= (ist_ff & ~pwdata[vsr_pkg::I_BITS-1:0]) | ev;
         end else begin
            ist_ff <= ist_ff | ev;
         end
         irq_ff <= |(ist_ff & imask_ff);
      end
   end

   // Build block, enter it, wait for completion, fetch status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff       <= H_IDLE;
         idx_ff      <= 4'h0;
         pb_we_ff    <= 1'b0;
         pb_addr_ff  <= 4'h0;
         pb_wdata_ff <= 16'h0000;
         go_ff       <= 1'b0;
         ack_ff      <= 1'b0;
         ret_ff      <= 16'h0000;
         irqseen_ff  <= 1'b0;
      end else begin
         pb_we_ff <= 1'b0;
         go_ff    <= 1'b0;
         ack_ff   <= 1'b0;
         case (st_ff)
            H_IDLE: if (start && !bad_lvl) begin
               st_ff  <= H_FILL;
               idx_ff <= 4'h0;
            end
            H_FILL: begin
               pb_we_ff    <= 1'b1;
               pb_addr_ff  <= idx_ff;
               pb_wdata_ff <= fill_w;
               idx_ff      <= idx_ff + 4'h1;
               if (idx_ff == vsr_pkg::PB_LAST) st_ff <= H_GO;
            end
            H_GO: begin
               go_ff <= 1'b1;
               st_ff <= H_WAIT;
            end
            H_WAIT: if (lnk.irq_req || !lnk.busy && !go_ff) begin
               irqseen_ff <= lnk.irq_req;
               pb_addr_ff <= vsr_pkg::PB_RETSTAT;
               st_ff      <= H_RD1;
            end
            H_RD1:  st_ff <= H_RD2;
            H_RD2: begin
               ret_ff <= lnk.pb_rdata;
               ack_ff <= irqseen_ff;
               st_ff  <= H_ACK;
            end
            H_ACK:  st_ff <= H_IDLE;
            default: st_ff <= H_IDLE;
         endcase
      end
   end

   assign lnk.pb_we       = pb_we_ff;
   assign lnk.pb_addr     = pb_addr_ff;
   assign lnk.pb_wdata    = pb_wdata_ff;
   assign lnk.mce_go      = go_ff;
   assign lnk.irq_ack     = ack_ff;
   assign lnk.init_we     = init_ff;
   assign lnk.init_freeze = frz_ff;
endmodule

// ---- test/vsr_link_properties.sv ----
`timescale 1ns/1ps
module vsr_link_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        pb_we,
   input wire logic [3:0]  pb_addr,
   input wire logic [15:0] pb_wdata,
   input wire logic        mce_go,
   input wire logic        busy,
   input wire logic        irq_req,
   input wire logic [2:0]  irq_priority_level,
   input wire logic [7:0]  irq_vec,
   input wire logic        irq_ack
);
   logic [15:0] vec_ff;
   logic [2:0]  lvl_ff;
   logic        ie_ff;
   // Block word writes that the interrupt and reserved-bit checks compare against
   wire vec_wr = pb_we && pb_addr == vsr_pkg::PB_VECTORS;
   wire lvl_wr = pb_we && pb_addr == vsr_pkg::PB_LEVEL;
   wire opt_wr = pb_we && pb_addr == vsr_pkg::PB_OPTS;
   wire bad_opt = opt_wr && (pb_wdata & ~vsr_pkg::OPT_MASK) != 16'h0000;
   wire bad_lvl = lvl_wr && (pb_wdata & ~vsr_pkg::LVL_MASK) != 16'h0000;
   wire bad_bus = pb_we && pb_addr == vsr_pkg::PB_BUSID &&
                  (pb_wdata & ~vsr_pkg::BUSID_MASK) != 16'h0000;

   // Shadow of the vector, level and enable words last sent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_ff <= 16'h0000;
         lvl_ff <= 3'h0;
         ie_ff  <= 1'b0;
      end else begin
         if (vec_wr) vec_ff <= pb_wdata;
         if (lvl_wr) lvl_ff <= pb_wdata[2:0];
         if (opt_wr) ie_ff <= pb_wdata[vsr_pkg::OPT_IE_BIT];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Link protocol and completion relations
   property p_code;
      pb_we && pb_addr == vsr_pkg::PB_CODE |-> pb_wdata == vsr_pkg::CMD_BUS_RST;
   endproperty
   property p_resv; pb_we |-> !bad_opt && !bad_lvl && !bad_bus; endproperty
   property p_fill; mce_go |-> $past(pb_we) && $past(pb_addr) == vsr_pkg::PB_LAST; endproperty
   property p_busy; mce_go |=> busy; endproperty
   property p_done; $rose(busy) |-> ##[1:200] !busy; endproperty
   property p_ie; irq_req |-> ie_ff; endproperty
   property p_lvl;
      irq_req |-> irq_priority_level == lvl_ff && irq_priority_level != 3'h0;
   endproperty
   property p_vec; irq_req |-> irq_vec == vec_ff[15:8]; endproperty
   property p_hold; irq_req && !irq_ack |=> irq_req; endproperty
   property p_ack; irq_ack |=> !irq_req; endproperty
   property p_open; irq_req |-> busy; endproperty
   a_code: assert property (p_code) else $error("bad command code");
   a_resv: assert property (p_resv) else $error("reserved bits set");
   a_fill: assert property (p_fill) else $error("go before bus id word");
   a_busy: assert property (p_busy) else $error("go not taken");
   a_done: assert property (p_done) else $error("command never ends");
   a_ie: assert property (p_ie) else $error("irq without enable");
   a_lvl: assert property (p_lvl) else $error("wrong irq level");
   a_vec: assert property (p_vec) else $error("wrong irq vector");
   a_hold: assert property (p_hold) else $error("irq dropped early");
   a_ack: assert property (p_ack) else $error("irq kept after ack");
   a_open: assert property (p_open) else $error("irq after command end");
   // Main scenarios
   c_go: cover property (mce_go);
   c_ack: cover property (irq_req && irq_ack);
   c_port1: cover property (pb_we && pb_addr == vsr_pkg::PB_BUSID && pb_wdata[15]);
endmodule

// ---- test/scsi_bus_reset_command_bench.sv ----
`timescale 1ns/1ps
module scsi_bus_reset_command_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, irq_ff;
   logic [7:0]  paddr, q_act_p0, q_act_p1, q_unfreeze, abort_stat_ff, frozen_ff, ab_mask, vec_got;
   logic [31:0] pwdata, prdata_ff, rd;
   logic [1:0]  scsi_rst_ff, rst_seen;
   logic [2:0]  abort_queue_ff, lvl_got;
   logic        abort_valid_ff, er, irq_seen;
   int          num_errors, comparisons, ab_cnt, rst_cyc;

   vsr_if u_vsr_if ();
   vsr_dev #(.NQ(8), .RST_LEN(4)) u_vsr_dev (.pclk(pclk), .presetn(presetn), .lnk(u_vsr_if),
      .q_act_p0(q_act_p0), .q_act_p1(q_act_p1), .q_unfreeze(q_unfreeze),
      .scsi_rst_ff(scsi_rst_ff), .abort_valid_ff(abort_valid_ff),
      .abort_queue_ff(abort_queue_ff), .abort_stat_ff(abort_stat_ff), .frozen_ff(frozen_ff));
   vsr_host u_vsr_host (.pclk(pclk), .presetn(presetn), .lnk(u_vsr_if), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .irq_ff(irq_ff));
   vsr_link_properties u_vsr_link_properties (.pclk(pclk), .presetn(presetn),
      .pb_we(u_vsr_if.pb_we), .pb_addr(u_vsr_if.pb_addr), .pb_wdata(u_vsr_if.pb_wdata),
      .mce_go(u_vsr_if.mce_go), .busy(u_vsr_if.busy), .irq_req(u_vsr_if.irq_req),
      .irq_priority_level(u_vsr_if.irq_priority_level), .irq_vec(u_vsr_if.irq_vec),
      .irq_ack(u_vsr_if.irq_ack));

   // 40 MHz clock
   always #12.5 pclk = ~pclk;

   // Verdict and end of run
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // One APB transfer; read data and error land in rd and er
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_ff !== 1'b1 && n < 50);
      if (pready_ff !== 1'b1) begin
         check(0, 1, "pready timeout");
         results();
      end
      rd = prdata_ff;
      er = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      check(rd, exp, msg);
   endtask

   // Bounded wait for the link busy level
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (u_vsr_if.busy !== lvl && n < 300) begin
         @(posedge pclk);
         n++;
      end
      if (u_vsr_if.busy !== lvl) begin
         check(0, 1, "busy timeout");
         results();
      end
   endtask

   task automatic run_cmd(input logic [31:0] ctrl);
      ab_cnt = 0;
      ab_mask = 8'h00;
      rst_seen = 2'b00;
      rst_cyc = 0;
      irq_seen = 1'b0;
      apb(1'b1, vsr_pkg::A_CTRL, ctrl);
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (2) @(posedge pclk);
   endtask

   // Watches the user side of the device and the interrupt request
   always @(posedge pclk) begin
      if (abort_valid_ff === 1'b1) begin
         ab_cnt++;
         ab_mask[abort_queue_ff] = 1'b1;
         check({24'h0, abort_stat_ff}, {24'h0, vsr_pkg::ST_SCSI_RST}, "abort status");
      end
      rst_seen = rst_seen | scsi_rst_ff;
      if (scsi_rst_ff !== 2'b00) rst_cyc++;
      if (u_vsr_if.irq_req === 1'b1) begin
         irq_seen = 1'b1;
         vec_got = u_vsr_if.irq_vec;
         lvl_got = u_vsr_if.irq_priority_level;
      end
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = 8'h00;
      pwdata = 32'h0;
      q_act_p0 = 8'h00;
      q_act_p1 = 8'h00;
      q_unfreeze = 8'h00;
      num_errors = 0;
      comparisons = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values and an unmapped address
      rdchk(vsr_pkg::A_INT_STAT, 32'h0, "int stat reset");
      rdchk(vsr_pkg::A_INT_MASK, 32'h0, "int mask reset");
      rdchk(vsr_pkg::A_STAT, 32'h0, "stat reset");
      apb(1'b1, 8'h40, 32'hFFFF_FFFF);
      check(er, 1, "unmapped write error");
      rdchk(8'h40, 32'h0, "unmapped read");
      check(er, 1, "unmapped read error");
      check(irq_ff, 0, "irq at reset");
      $display("test registers done");
      // Port 0 reset with freeze and interrupt
      apb(1'b1, vsr_pkg::A_INT_MASK, 32'h1);
      apb(1'b1, vsr_pkg::A_VEC, 32'hA55A);
      apb(1'b1, vsr_pkg::A_LVL, 32'h5);
      apb(1'b1, vsr_pkg::A_CTRL, 32'h18);
      q_act_p0 <= 8'h25;
      q_act_p1 <= 8'h5A;
      run_cmd(32'h3);
      check(rst_seen, 2'b01, "port 0 reset");
      check(rst_cyc, 4, "reset length");
      check(ab_mask, 8'h25, "aborted queues");
      check(ab_cnt, 3, "abort count");
      check(frozen_ff, 8'h25, "frozen queues");
      check(irq_seen, 1, "irq raised");
      check(vec_got, 8'hA5, "normal vector");
      check(lvl_got, 3'h5, "irq level");
      rdchk(vsr_pkg::A_STAT, 32'h0, "status ok");
      rdchk(vsr_pkg::A_INT_STAT, 32'h9, "done and sense");
      check(irq_ff, 1, "irq out high");
      apb(1'b1, vsr_pkg::A_INT_STAT, 32'h9);
      rdchk(vsr_pkg::A_INT_STAT, 32'h0, "w1c cleared");
      check(irq_ff, 0, "irq out low");
      $display("test port0 done");
      // Port 1 reset, no freeze, no interrupt
      @(posedge pclk) q_unfreeze <= 8'hFF;
      @(posedge pclk) q_unfreeze <= 8'h00;
      repeat (2) @(posedge pclk);
      check(frozen_ff, 8'h00, "unfreeze");
      apb(1'b1, vsr_pkg::A_CTRL, 32'h10);
      q_act_p1 <= 8'h81;
      run_cmd(32'h5);
      check(rst_seen, 2'b10, "port 1 reset");
      check(ab_mask, 8'h81, "aborted queues");
      check(ab_cnt, 2, "abort count");
      check(frozen_ff, 8'h00, "no freeze");
      check(irq_seen, 0, "no irq");
      rdchk(vsr_pkg::A_INT_STAT, 32'h9, "done flags");
      apb(1'b1, vsr_pkg::A_INT_STAT, 32'h9);
      $display("test port1 done");
      // Level zero with interrupt enabled is refused
      apb(1'b1, vsr_pkg::A_INT_MASK, 32'h0);
      apb(1'b1, vsr_pkg::A_LVL, 32'h0);
      irq_seen = 1'b0;
      apb(1'b1, vsr_pkg::A_CTRL, 32'h3);
      repeat (30) @(posedge pclk);
      check(u_vsr_if.busy, 0, "refused go");
      check(irq_seen, 0, "refused irq");
      rdchk(vsr_pkg::A_INT_STAT, 32'h4, "refused flag");
      check(irq_ff, 0, "masked irq");
      apb(1'b1, vsr_pkg::A_INT_MASK, 32'h4);
      rdchk(vsr_pkg::A_INT_MASK, 32'h4, "mask readback");
      check(irq_ff, 1, "unmasked irq");
      apb(1'b1, vsr_pkg::A_INT_STAT, 32'h4);
      rdchk(vsr_pkg::A_INT_STAT, 32'h0, "refused cleared");
      check(irq_ff, 0, "irq cleared");
      $display("test refused done");
      results();
   end
endmodule
